// *** verilog/adc_readout_pkg.sv ***
// ****************************************************************
// timing and frame constants
// ****************************************************************
package adc_readout_pkg;

   localparam int CLK_PERIOD_NS = 8;
   localparam int CLK_KHZ = 125000;
   localparam int SCLK_MAX_KHZ = 4800;
   localparam int SCLK_MIN_KHZ = 100;
   // least half period rounds up so the link never exceeds its top rate
   localparam int HALF_MIN_CYCLES = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
   // longest half period rounds down so the link never drops below its floor
   localparam int HALF_MAX_CYCLES = CLK_KHZ / (2 * SCLK_MIN_KHZ);
   localparam int T_CSW_NS = 50;
   localparam int CSW_CYCLES = (T_CSW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;

   localparam int CNT_W = 10;
   localparam int BIT_W = 5;
   localparam int FRAME_W = 24;
   localparam int RESULT_W = 14;
   localparam int SUB_W = 2;
   localparam int SUB_POS = 0;
   localparam int RESULT_POS = 2;

   localparam logic [BIT_W-1:0] FRAME_CLOCKS = 5'h18;
   localparam logic [BIT_W-1:0] ACQ_END_EDGE = 5'h06;
   localparam logic [2:0] BYTE_BOUNDARY = 3'h0;
   localparam logic [CNT_W-1:0] SAMPLE_DELAY = 10'h002;

   typedef enum {
      ST_IDLE,
      ST_LEAD,
      ST_HIGH,
      ST_LOW,
      ST_GAP,
      ST_CSW
   } host_state_type;

endpackage : adc_readout_pkg

// *** verilog/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// two-stage synchroniser for a level from a pin
// ****************************************************************
module pin_sync (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin_in,
   output logic pin_sync_out
);

   typedef struct packed {
      logic meta;
      logic stable;
   } sync_type;

   sync_type sync_reg;
   sync_type sync_next;

   // only the second stage may read the first
   always_comb begin
      sync_next.meta = pin_in;
      sync_next.stable = sync_reg.meta;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign pin_sync_out = sync_reg.stable;

endmodule : pin_sync
`default_nettype wire

// *** verilog/adc_readout_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_readout_host
   import adc_readout_pkg::*;
#(
   parameter int HALF_CYCLES = HALF_MIN_CYCLES,
   parameter int GAP_CYCLES = 2 * HALF_MIN_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   input wire logic byte_mode,
   input wire logic abort,
   input wire logic dout_pin,
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic busy,
   output logic result_valid,
   output logic [RESULT_W-1:0] result,
   output logic [SUB_W-1:0] sub_bits,
   output logic acq_done,
   output logic aborted
);

   // ****************************************************************
   // derived counts
   // ****************************************************************
   localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
   localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYCLES - 1);
   localparam logic [CNT_W-1:0] CSW_LAST = CNT_W'(CSW_CYCLES - 1);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      host_state_type state;
      logic [CNT_W-1:0] cnt;
      logic [BIT_W-1:0] edges;
      logic [FRAME_W-1:0] shift;
      logic bytes;
      logic cs_n;
      logic sclk;
      logic busy;
      logic valid;
      logic [RESULT_W-1:0] result;
      logic [SUB_W-1:0] sub;
      logic acq;
      logic aborted;
   } host_type;

   host_type host_reg;
   host_type host_next;
   logic dout_sync;

   // ****************************************************************
   // data line crossing into the system clock
   // ****************************************************************
   pin_sync u_dout_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_in(dout_pin),
      .pin_sync_out(dout_sync)
   );

   // ****************************************************************
   // frame sequencer
   // ****************************************************************
   always_comb begin
      host_next = host_reg;
      host_next.valid = 1'b0;
      host_next.acq = 1'b0;
      host_next.aborted = 1'b0;
      unique case (host_reg.state)
         ST_IDLE: begin
            if (start) begin
               host_next.cs_n = 1'b0;
               host_next.busy = 1'b1;
               host_next.bytes = byte_mode;
               host_next.cnt = '0;
               host_next.edges = '0;
               host_next.shift = '0;
               host_next.state = ST_LEAD;
            end
         end
         ST_LEAD: begin
            // first rise waits half a period so the first zero is settled
            if (host_reg.cnt == HALF_LAST) begin
               host_next.sclk = 1'b1;
               host_next.cnt = '0;
               host_next.state = ST_HIGH;
            end else begin
               host_next.cnt = host_reg.cnt + 1'b1;
            end
         end
         ST_HIGH: begin
            // the pin value at the rising edge reaches the sync output two cycles on
            if (host_reg.cnt == SAMPLE_DELAY) begin
               host_next.shift = {host_reg.shift[FRAME_W-2:0], dout_sync};
            end
            if (host_reg.cnt == HALF_LAST) begin
               host_next.sclk = 1'b0;
               host_next.cnt = '0;
               host_next.edges = host_reg.edges + 1'b1;
               if (host_reg.edges + 1'b1 == ACQ_END_EDGE) begin
                  host_next.acq = 1'b1;
               end
               host_next.state = ST_LOW;
            end else begin
               host_next.cnt = host_reg.cnt + 1'b1;
            end
         end
         ST_LOW: begin
            if (host_reg.cnt == HALF_LAST) begin
               host_next.cnt = '0;
               if (host_reg.edges == FRAME_CLOCKS) begin
                  // chip select rises half a period after the 24th fall
                  host_next.cs_n = 1'b1;
                  host_next.result = host_reg.shift[RESULT_POS +: RESULT_W];
                  host_next.sub = host_reg.shift[SUB_POS +: SUB_W];
                  host_next.valid = 1'b1;
                  host_next.state = ST_CSW;
               end else if (host_reg.bytes && host_reg.edges[2:0] == BYTE_BOUNDARY) begin
                  host_next.state = ST_GAP;
               end else begin
                  host_next.sclk = 1'b1;
                  host_next.state = ST_HIGH;
               end
            end else begin
               host_next.cnt = host_reg.cnt + 1'b1;
            end
         end
         ST_GAP: begin
            // clock parked low between bytes; chip select stays low
            if (host_reg.cnt == GAP_LAST) begin
               host_next.cnt = '0;
               host_next.sclk = 1'b1;
               host_next.state = ST_HIGH;
            end else begin
               host_next.cnt = host_reg.cnt + 1'b1;
            end
         end
         ST_CSW: begin
            // starts during the wait are ignored, not queued
            if (host_reg.cnt == CSW_LAST) begin
               host_next.busy = 1'b0;
               host_next.cnt = '0;
               host_next.state = ST_IDLE;
            end else begin
               host_next.cnt = host_reg.cnt + 1'b1;
            end
         end
      endcase
      // ****************************************************************
      // abort: chip select up at once, then the same high wait
      // ****************************************************************
      if (abort && host_reg.state != ST_IDLE && host_reg.state != ST_CSW) begin
         host_next.cs_n = 1'b1;
         host_next.sclk = 1'b0;
         host_next.cnt = '0;
         host_next.acq = 1'b0;
         host_next.valid = 1'b0;
         host_next.aborted = 1'b1;
         host_next.state = ST_CSW;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         host_reg.state <= ST_IDLE;
         host_reg.cnt <= '0;
         host_reg.edges <= '0;
         host_reg.shift <= '0;
         host_reg.bytes <= 1'b0;
         host_reg.cs_n <= 1'b1;
         host_reg.sclk <= 1'b0;
         host_reg.busy <= 1'b0;
         host_reg.valid <= 1'b0;
         host_reg.result <= '0;
         host_reg.sub <= '0;
         host_reg.acq <= 1'b0;
         host_reg.aborted <= 1'b0;
      end else begin
         host_reg <= host_next;
      end
   end

   // ****************************************************************
   // outputs, each a field of the state register
   // ****************************************************************
   assign cs_n_pin = host_reg.cs_n;
   assign sclk_pin = host_reg.sclk;
   assign busy = host_reg.busy;
   assign result_valid = host_reg.valid;
   assign result = host_reg.result;
   assign sub_bits = host_reg.sub;
   assign acq_done = host_reg.acq;
   assign aborted = host_reg.aborted;

endmodule : adc_readout_host
`default_nettype wire

// *** testbench/adc_readout_host_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_readout_host_monitor
   import adc_readout_pkg::*;
#(
   parameter int HALF_CYCLES = HALF_MIN_CYCLES,
   parameter int GAP_CYCLES = 2 * HALF_MIN_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   input wire logic byte_mode,
   input wire logic abort,
   input wire logic dout_pin,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic busy,
   input wire logic result_valid,
   input wire logic [RESULT_W-1:0] result,
   input wire logic [SUB_W-1:0] sub_bits,
   input wire logic acq_done,
   input wire logic aborted
);
   logic prev_sclk_reg;
   logic [BIT_W-1:0] fall_cnt_reg;
   int hi_cnt_reg;
   int lo_cnt_reg;
   logic mode_reg;
   // falls and high time counted here, too long for a repetition
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev_sclk_reg <= 1'b0;
         fall_cnt_reg <= '0;
         hi_cnt_reg <= 0;
         lo_cnt_reg <= 0;
         mode_reg <= 1'b0;
      end else begin
         prev_sclk_reg <= sclk_pin;
         hi_cnt_reg <= sclk_pin ? hi_cnt_reg + 1 : 0;
         lo_cnt_reg <= (cs_n_pin || sclk_pin) ? 0 : lo_cnt_reg + 1;
         // the mode is latched where the design takes the start
         if (start && !busy && cs_n_pin)
            mode_reg <= byte_mode;
         if (cs_n_pin)
            fall_cnt_reg <= '0;
         else if (prev_sclk_reg && !sclk_pin)
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_take; start && !busy && cs_n_pin; endsequence
   sequence s_end; $rose(cs_n_pin) ##0 !aborted; endsequence
   property p_start; s_take |=> !cs_n_pin && busy; endproperty
   property p_idle; cs_n_pin |-> !sclk_pin; endproperty
   property p_high; $fell(sclk_pin) && !aborted |-> hi_cnt_reg == HALF_CYCLES; endproperty
   property p_len; s_end |-> fall_cnt_reg == FRAME_CLOCKS; endproperty
   property p_valid; s_end |-> result_valid; endproperty
   property p_abort; aborted |-> cs_n_pin && !sclk_pin && !result_valid; endproperty
   property p_acq; acq_done |-> $fell(sclk_pin) && fall_cnt_reg == 5'h05; endproperty
   property p_csw; $rose(cs_n_pin) |-> cs_n_pin [*7]; endproperty
   property p_pulse; result_valid |=> !result_valid; endproperty
   property p_low; $rose(sclk_pin) |-> lo_cnt_reg == ((mode_reg && (fall_cnt_reg == 5'h08 ||
      fall_cnt_reg == 5'h10)) ? HALF_CYCLES + GAP_CYCLES : HALF_CYCLES); endproperty
   a_start: assert property (p_start) else $error("no select after start");
   a_idle: assert property (p_idle) else $error("clock moves while idle");
   a_high: assert property (p_high) else $error("clock high time");
   a_len: assert property (p_len) else $error("frame clock count");
   a_valid: assert property (p_valid) else $error("no result at frame end");
   a_abort: assert property (p_abort) else $error("abort answer");
   a_acq: assert property (p_acq) else $error("acquisition end edge");
   a_csw: assert property (p_csw) else $error("select high too short");
   a_pulse: assert property (p_pulse) else $error("result pulse length");
   a_low: assert property (p_low) else $error("clock low time or byte gap");
endmodule : adc_readout_host_monitor
bind adc_readout_host adc_readout_host_monitor #(.HALF_CYCLES(HALF_CYCLES),
   .GAP_CYCLES(GAP_CYCLES)) adc_readout_host_monitor_inst (.clk_sys(clk_sys), .rst(rst),
   .start(start), .byte_mode(byte_mode), .abort(abort), .dout_pin(dout_pin),
   .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .busy(busy), .result_valid(result_valid),
   .result(result), .sub_bits(sub_bits), .acq_done(acq_done), .aborted(aborted));
`default_nettype wire

// *** testbench/adc_converter_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_converter_model (
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic [13:0] code,
   input wire logic [1:0] sub_in,
   output logic dout_pin
);
   logic [23:0] frame_reg = '0;
   int fall_count = 0;
   logic last_reg = 1'b0;
   // select fall restarts, also after an abort
   always @(negedge cs_n_pin) begin
      fall_count = 0;
      last_reg = 1'b0;
   end
   // data moves only on falling clock; zeros after the sub-bits
   always @(negedge sclk_pin) begin
      if (!cs_n_pin) begin
         fall_count = fall_count + 1;
         if (fall_count == 6)
            frame_reg = {8'h00, code, sub_in};
         last_reg = (fall_count < 24) ? frame_reg[23 - fall_count] : 1'b0;
      end
   end
   // no pull resistor: a floating line shows the inverse of the last bit
   assign dout_pin = cs_n_pin ? ~last_reg : last_reg;
endmodule : adc_converter_model
`default_nettype wire

// *** testbench/adc_readout_host_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_readout_host_tb;
   import adc_readout_pkg::*;
   logic clk_sys, rst, start, byte_mode, abort, dout_pin, cs_n_pin, sclk_pin, busy;
   logic result_valid, acq_done, aborted;
   logic [RESULT_W-1:0] result, code;
   logic [SUB_W-1:0] sub_bits, sub_in;
   int miscompares = 0;
   int checks = 0;
   int n;
   // rows: byte mode, code, sub-bits; full scale, patterns, one lsb
   logic [16:0] rows [4] = '{17'h0FFFF, 17'h1AAA9, 17'h00006, 17'h15554};
   adc_readout_host #(.HALF_CYCLES(4), .GAP_CYCLES(2)) adc_readout_host_inst (
      .clk_sys(clk_sys), .rst(rst), .start(start), .byte_mode(byte_mode), .abort(abort),
      .dout_pin(dout_pin), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .busy(busy),
      .result_valid(result_valid), .result(result), .sub_bits(sub_bits),
      .acq_done(acq_done), .aborted(aborted));
   adc_converter_model adc_converter_model_inst (.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
      .code(code), .sub_in(sub_in), .dout_pin(dout_pin));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // 0 result, 1 abort, 2 acquisition end
   task automatic wait_for(input int which);
      for (n = 0; n < 1000; n++) begin
         @(posedge clk_sys);
         #1;
         if ((which == 0 ? result_valid : which == 1 ? aborted : acq_done) === 1'b1)
            return;
      end
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test();
   endtask : wait_for
   // a start during the select-high wait is ignored, so wait for idle, then hold until taken
   task automatic frame(input logic [16:0] row);
      @(posedge clk_sys);
      #1;
      for (n = 0; n < 50 && busy !== 1'b0; n++)
         @(posedge clk_sys) #1;
      if (busy !== 1'b0) begin
         miscompares++;
         $display("unexpected at %0t: still busy", $time);
         end_of_test();
      end
      byte_mode = row[16];
      code = row[15:2];
      sub_in = row[1:0];
      start = 1'b1;
      for (n = 0; n < 50 && busy !== 1'b1; n++)
         @(posedge clk_sys) #1;
      start = 1'b0;
      if (busy !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: start not taken", $time);
         end_of_test();
      end
   endtask : frame
   initial begin
      rst = 1'b1;
      start = 1'b0;
      byte_mode = 1'b0;
      abort = 1'b0;
      code = '0;
      sub_in = '0;
      repeat (6) @(posedge clk_sys);
      #1;
      check(cs_n_pin === 1'b1 && sclk_pin === 1'b0 && busy === 1'b0, "reset pins");
      check(result_valid === 1'b0 && result === '0 && sub_bits === '0, "reset result");
      rst = 1'b0;
      foreach (rows[i]) begin
         frame(rows[i]);
         wait_for(0);
         check(result === rows[i][15:2], "result");
         check(sub_bits === rows[i][1:0], "sub-bits");
         $display("test %0d done", i);
      end
      // abort right after acquisition: old result must stay
      frame(17'h0ABCD);
      wait_for(2);
      abort = 1'b1;
      wait_for(1);
      abort = 1'b0;
      check(cs_n_pin === 1'b1 && result === 14'h1555, "abort");
      $display("test abort done");
      frame(17'h0ABCD);
      wait_for(0);
      check(result === 14'h2AF3 && sub_bits === 2'h1, "after abort");
      $display("test restart done");
      end_of_test();
   end
endmodule : adc_readout_host_tb
`default_nettype wire
